/* File: iwr_pkg.sv */
// constants shared by the i2c wait and release control block
package iwr_pkg;

   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] IWR_OFF_CTRL = 8'h00;
   localparam logic [7:0] IWR_OFF_STATUS = 8'h04;
   localparam logic [7:0] IWR_OFF_FLAG = 8'h08;
   localparam logic [7:0] IWR_OFF_IRQ_STAT = 8'h0c;
   localparam logic [7:0] IWR_OFF_IRQ_MASK = 8'h10;

   // ------------------------------------------------------------------
   // control register field positions
   // ------------------------------------------------------------------
   localparam int IWR_CTRL_EN = 7;
   localparam int IWR_CTRL_EXIT = 6;
   localparam int IWR_CTRL_WREL = 5;
   localparam int IWR_CTRL_SPIE = 4;
   localparam int IWR_CTRL_WTIM = 3;

   // ------------------------------------------------------------------
   // status / flag / interrupt field positions
   // ------------------------------------------------------------------
   localparam int IWR_ST_MASTER = 7;
   localparam int IWR_ST_EXT = 6;
   localparam int IWR_ST_MATCH = 5;
   localparam int IWR_ST_DIR = 4;
   localparam int IWR_ST_ACK = 3;
   localparam int IWR_ST_START = 2;
   localparam int IWR_ST_STOP = 1;
   localparam int IWR_ST_WAIT = 0;
   localparam int IWR_FL_BUSY = 0;
   localparam int IWR_FL_SFAIL = 1;
   localparam int IWR_FL_SCL = 2;
   localparam int IWR_FL_SDA = 3;
   localparam int IWR_IRQ_XFER = 0;
   localparam int IWR_IRQ_STOP = 1;

   // ------------------------------------------------------------------
   // reset values and clock counts
   // ------------------------------------------------------------------
   localparam logic [7:0] IWR_RST_BYTE = 8'h00;
   localparam logic [3:0] IWR_CNT_PRE = 4'hf;
   localparam logic [3:0] IWR_CNT_EIGHT = 4'h8;
   localparam logic [3:0] IWR_CNT_NINE = 4'h9;

   // link phase, one-hot
   typedef enum logic [3:0] {
      IWR_IDLE = 4'b0001,
      IWR_ADDR = 4'b0010,
      IWR_DATA = 4'b0100,
      IWR_STBY = 4'b1000
   } iwr_phase_t;

endpackage : iwr_pkg

/* File: iwr_sync.sv */
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module iwr_sync
   import iwr_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // refuse an empty synchroniser
   if (WIDTH < 1) begin : g_bad_width
      $error("iwr_sync needs at least one bit");
   end

   // first stage feeds only the second; idle bus level is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule : iwr_sync

/* File: iwr_ctrl.sv */
// i2c wait, release and stop interrupt control with apb registers
//
// Behaviour
// - after exit, stay standby until stop, or match/extension after start
// - exit bit set by software only, self-clears, zero after reset
// - writing one to wait release ends the wait; bit self-clears
// - disabling clears status, start-fail, busy and line monitors
// - exit and wait release do nothing while the unit is disabled
// - enabling with clock high and data low detects a start at once
// - exit and wait release bits always read back as zero
// - stop condition raises transfer interrupt only when enabled
// - timing bit zero: interrupt and wait at eighth falling edge
// - timing bit one: interrupt and wait at ninth falling edge
// - addressed transfer interrupts at ninth falling edge, eighth with extension code
// - master waits at ninth falling edge of address transfer
// - matched slave waits at ninth falling edge after acknowledge
// - slave with extension code waits at eighth falling edge
// - stop interrupt enable and timing bits change only by writes
// - exit releases both lines and clears triggers and status bits except stop
// - disabled unit stops internal operation, status held in reset
`timescale 1ns/1ps
module iwr_ctrl
   import iwr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe_n,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic master_i,
   input wire logic master_scl_low_i,
   input wire logic sda_low_i,
   input wire logic addr_match_i,
   input wire logic ext_code_i,
   input wire logic dir_i,
   input wire logic ack_seen_i,
   input wire logic start_fail_i,
   output logic trig_clear,
   output logic transfer_irq
);

   if (ADDR_W < 5) begin : g_bad_addr
      $error("iwr_ctrl needs at least five address bits");
   end

   // ------------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------------
   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;

   iwr_sync #(.WIDTH(2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({scl_i, sda_i}),
      .sync_out(pins_s)
   );
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic en_q, spie_q, wtim_q;
   logic scl_d1_q, sda_d1_q, en_d1_q;
   logic exit_q, wrel_q;
   logic wait_q, busy_q, sfail_q, start_seen_q;
   logic mst_q, ext_q, match_q, dir_q, ack_q, std_q, spd_q;
   logic [1:0] irq_stat_q, irq_mask_q;
   logic [3:0] cnt_q, cnt_d;
   iwr_phase_t phase_q, phase_d;
   logic [31:0] prdata_q;
   logic scl_oe_n_q, sda_oe_n_q, trig_clear_q;

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   wire setup = psel && !penable;
   wire wr_acc = psel && penable && pwrite;
   wire [7:0] addr8 = 8'(paddr);
   wire hit_ctrl = addr8 == IWR_OFF_CTRL;
   wire hit_stat = addr8 == IWR_OFF_STATUS;
   wire hit_flag = addr8 == IWR_OFF_FLAG;
   wire hit_istat = addr8 == IWR_OFF_IRQ_STAT;
   wire hit_imask = addr8 == IWR_OFF_IRQ_MASK;
   wire hit_any = hit_ctrl | hit_stat | hit_flag | hit_istat | hit_imask;
   wire wr_ctrl = wr_acc && hit_ctrl;
   wire exit_req = wr_ctrl && en_q && pwdata[IWR_CTRL_EXIT];
   wire wrel_req = wr_ctrl && en_q && pwdata[IWR_CTRL_WREL];

   // ------------------------------------------------------------------
   // line events
   // ------------------------------------------------------------------
   wire scl_fall = en_q && scl_d1_q && !scl_s;
   wire stop_det = en_q && scl_s && scl_d1_q && !sda_d1_q && sda_s;
   wire en_start = en_q && !en_d1_q && scl_s && !sda_s;
   wire start_det = (en_q && scl_s && scl_d1_q && sda_d1_q && !sda_s)
      || en_start;

   // ------------------------------------------------------------------
   // wait point selection
   // ------------------------------------------------------------------
   wire in_addr = phase_q == IWR_ADDR;
   wire in_data = phase_q == IWR_DATA;
   wire ext_now = (ext_q || ext_code_i) && !master_i;
   wire match_now = match_q || addr_match_i;
   wire [3:0] data_pt = wtim_q ? IWR_CNT_NINE : IWR_CNT_EIGHT;
   wire [3:0] addr_pt = ext_now ? IWR_CNT_EIGHT : IWR_CNT_NINE;
   wire [3:0] wait_pt = in_addr ? addr_pt : data_pt;
   wire addressed = master_i || match_now || ext_now;
   wire wait_hit = scl_fall && cnt_d == wait_pt
      && (in_data || (in_addr && addressed));
   wire byte_end = scl_fall && cnt_d == IWR_CNT_NINE;
   wire irq_xfer = wait_hit;
   wire irq_stop = stop_det && spie_q;
   wire [1:0] irq_set = {irq_stop, irq_xfer};
   wire [1:0] irq_clr = (wr_acc && hit_istat) ? 2'(pwdata) : 2'h0;

   // ------------------------------------------------------------------
   // clock counter: falling edges since the start of the byte
   // ------------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      if (start_det) begin
         cnt_d = IWR_CNT_PRE;
      end else if (scl_fall) begin
         if (cnt_q == IWR_CNT_PRE) begin
            cnt_d = 4'h0;
         end else if (cnt_q == IWR_CNT_NINE) begin
            cnt_d = 4'h1;
         end else begin
            cnt_d = cnt_q + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // link phase machine
   // ------------------------------------------------------------------
   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         IWR_IDLE: begin
            if (start_det) begin
               phase_d = IWR_ADDR;
            end
         end
         IWR_ADDR, IWR_DATA: begin
            if (stop_det) begin
               phase_d = IWR_IDLE;
            end else if (start_det) begin
               phase_d = IWR_ADDR;
            end else if (in_addr && byte_end) begin
               phase_d = addressed ? IWR_DATA : IWR_IDLE;
            end
         end
         IWR_STBY: begin
            // leave standby only on entry conditions
            if (stop_det) begin
               phase_d = IWR_IDLE;
            end else if (start_seen_q && (addr_match_i || ext_code_i)) begin
               phase_d = IWR_ADDR;
            end
         end
         default: phase_d = IWR_IDLE;
      endcase
      if (exit_req) begin
         phase_d = IWR_STBY;
      end
   end

   // phase, counter and start flag hold in reset while disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= IWR_IDLE;
         cnt_q <= IWR_CNT_PRE;
         start_seen_q <= 1'b0;
      end else if (!en_q) begin
         phase_q <= IWR_IDLE;
         cnt_q <= IWR_CNT_PRE;
         start_seen_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         start_seen_q <= exit_req ? 1'b0 : (start_seen_q | start_det);
      end
   end

   // line history for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
         en_d1_q <= 1'b0;
      end else begin
         scl_d1_q <= scl_s;
         sda_d1_q <= sda_s;
         en_d1_q <= en_q;
      end
   end

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------
   // stop enable and timing change only by writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         spie_q <= 1'b0;
         wtim_q <= 1'b0;
      end else if (wr_ctrl) begin
         en_q <= pwdata[IWR_CTRL_EN];
         spie_q <= pwdata[IWR_CTRL_SPIE];
         wtim_q <= pwdata[IWR_CTRL_WTIM];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exit_q <= 1'b0;
         wrel_q <= 1'b0;
      end else begin
         exit_q <= exit_req;
         wrel_q <= wrel_req;
      end
   end

   // ------------------------------------------------------------------
   // wait state
   // ------------------------------------------------------------------
   // set at wait point, held until released
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 1'b0;
      end else if (!en_q || exit_req) begin
         wait_q <= 1'b0;
      end else if (wait_hit) begin
         wait_q <= 1'b1;
      end else if (wrel_req) begin
         wait_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // status and flags
   // ------------------------------------------------------------------
   // cleared on disable; all but stop cleared on exit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {mst_q, ext_q, match_q, dir_q, ack_q, std_q, spd_q} <= 7'h00;
      end else if (!en_q) begin
         {mst_q, ext_q, match_q, dir_q, ack_q, std_q, spd_q} <= 7'h00;
      end else if (exit_req) begin
         {mst_q, ext_q, match_q, dir_q, ack_q, std_q} <= 6'h00;
         spd_q <= spd_q | stop_det;
      end else begin
         mst_q <= master_i;
         ext_q <= start_det ? 1'b0 : (ext_q | ext_code_i);
         match_q <= start_det ? 1'b0 : (match_q | addr_match_i);
         dir_q <= dir_i;
         ack_q <= ack_seen_i;
         std_q <= start_det | (std_q & !stop_det & !byte_end);
         spd_q <= stop_det | (spd_q & !start_det);
      end
   end

   // busy and start-fail reset while disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         sfail_q <= 1'b0;
      end else if (!en_q) begin
         busy_q <= 1'b0;
         sfail_q <= 1'b0;
      end else begin
         busy_q <= start_det | (busy_q & !stop_det);
         sfail_q <= start_fail_i | (sfail_q & !start_det);
      end
   end

   // ------------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------------
   // set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= 2'h0;
         irq_mask_q <= 2'h0;
      end else begin
         irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
         if (wr_acc && hit_imask) begin
            irq_mask_q <= 2'(pwdata);
         end
      end
   end

   assign transfer_irq = |(irq_stat_q & irq_mask_q);

   // ------------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------------
   wire live = en_q && phase_d != IWR_STBY && !exit_req;
   wire scl_low_d = live && ((wait_q && !wrel_req) || wait_hit
      || master_scl_low_i);
   wire sda_low_d = live && sda_low_i;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_oe_n_q <= 1'b1;
         sda_oe_n_q <= 1'b1;
         trig_clear_q <= 1'b0;
      end else begin
         scl_oe_n_q <= !scl_low_d;
         sda_oe_n_q <= !sda_low_d;
         trig_clear_q <= exit_req || !en_q;
      end
   end

   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_n = scl_oe_n_q;
   assign sda_oe_n = sda_oe_n_q;
   assign trig_clear = trig_clear_q;

   // ------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------
   // command bits read as zero
   wire [31:0] rd_ctrl = {24'h0, en_q, 2'b00, spie_q, wtim_q, 3'b000};
   wire [31:0] rd_stat = {24'h0, mst_q, ext_q, match_q, dir_q, ack_q,
      std_q, spd_q, wait_q};
   wire [31:0] rd_flag = {28'h0, en_q & sda_s, en_q & scl_s, sfail_q,
      busy_q};
   wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : hit_stat ? rd_stat :
      hit_flag ? rd_flag : hit_istat ? {30'h0, irq_stat_q} :
      hit_imask ? {30'h0, irq_mask_q} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (setup) begin
         prdata_q <= rd_mux;
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit_any;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_exit_standby: assert property (exit_req |=> phase_q == IWR_STBY)
      else $error("exit did not enter standby");
   a_exit_pulse: assert property (exit_q |=> !exit_q || exit_req)
      else $error("exit bit did not clear");
   a_wrel_ends: assert property (wrel_q |-> !wait_q || $past(wait_hit))
      else $error("wait not released");
   a_off_clears: assert property (!en_q |=> !busy_q && !sfail_q && !std_q)
      else $error("flags survive disable");
   a_off_nocmd: assert property (!en_q |-> !exit_req && !wrel_req)
      else $error("command acted while disabled");
   a_en_start: assert property (en_start |=> std_q && busy_q)
      else $error("enable start missed");
   a_cmd_rd_zero: assert property (setup && hit_ctrl
      |=> prdata[6:5] == 2'b00)
      else $error("command bits read nonzero");
   a_stop_irq: assert property (stop_det && !spie_q
      |=> !irq_stat_q[IWR_IRQ_STOP] || $past(irq_stat_q[IWR_IRQ_STOP]))
      else $error("stop irq while disabled");
   a_wait_eight: assert property (wait_hit && in_data && !wtim_q
      |-> cnt_d == 4'h8)
      else $error("data wait not at eighth");
   a_wait_nine: assert property (wait_hit && in_data && wtim_q
      |-> cnt_d == 4'h9)
      else $error("data wait not at ninth");
   a_addr_nine: assert property (wait_hit && in_addr && !ext_now
      |-> cnt_d == 4'h9 ##1 irq_stat_q[IWR_IRQ_XFER])
      else $error("address irq not at ninth");
   a_ext_eight: assert property (wait_hit && in_addr && ext_now
      |-> cnt_d == 4'h8)
      else $error("extension wait not at eighth");
   a_hold_low: assert property (wait_q && live && !wrel_req
      |=> !scl_oe_n)
      else $error("clock released during wait");
   a_exit_release: assert property (exit_req |=> scl_oe_n && sda_oe_n
      && trig_clear)
      else $error("lines not released on exit");

   c_data_wait: cover property (wait_hit && in_data ##[1:50] wrel_req);
   c_stop_irq: cover property (irq_stop);
   c_exit_back: cover property (exit_req ##[1:500] phase_q == IWR_ADDR);
   c_addr_wait: cover property (wait_hit && in_addr);

endmodule : iwr_ctrl

/* File: iwr_peer.sv */
// bus peer: another i2c master driving both open-drain lines
`timescale 1ns/1ps
module iwr_peer (
   input wire logic pclk,
   input wire logic scl,
   output logic scl_drv,
   output logic sda_drv
);
   // released lines float high through the pull-ups
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge pclk);
   endtask : hold
   task automatic set_sda(input logic v);
      sda_drv <= v;
      hold(4);
   endtask : set_sda
   task automatic start();
      set_sda(1'b0);
      scl_drv <= 1'b0;
      hold(4);
   endtask : start
   task automatic pulse(input int n);
      int t;
      for (int i = 0; i < n; i++) begin
         scl_drv <= 1'b1;
         t = 0;
         while (scl !== 1'b1 && t < 400) begin
            @(posedge pclk);
            t++;
         end
         hold(4);
         scl_drv <= 1'b0;
         hold(4);
      end
   endtask : pulse
   // data rises while clock high
   task automatic stop();
      set_sda(1'b0);
      scl_drv <= 1'b1;
      hold(4);
      set_sda(1'b1);
   endtask : stop
endmodule : iwr_peer

/* File: tb.sv */
// self-checking bench for the i2c wait and release control block
`timescale 1ns/1ps
module tb;
   import iwr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, trig_clear, transfer_irq;
   logic master_i, addr_match_i, ext_code_i, start_fail_i;
   logic master_scl_low_i, sda_low_i, dir_i, ack_seen_i;
   logic scl_drv, sda_drv;
   int n_fail, compares;
   // open-drain wires with pull-ups
   wire logic scl = scl_oe_n & scl_drv;
   wire logic sda = sda_oe_n & sda_drv;
   iwr_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
      .sda_i(sda), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .master_i(master_i),
      .master_scl_low_i(master_scl_low_i), .sda_low_i(sda_low_i),
      .addr_match_i(addr_match_i), .ext_code_i(ext_code_i),
      .dir_i(dir_i), .ack_seen_i(ack_seen_i),
      .start_fail_i(start_fail_i), .trig_clear(trig_clear),
      .transfer_irq(transfer_irq));
   iwr_peer peer_u (.pclk(pclk), .scl(scl), .scl_drv(scl_drv),
      .sda_drv(sda_drv));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : wt
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         $display("mismatch at %0t: no pready", $time);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_reset();
      rdc(IWR_OFF_CTRL, 32'h0);
      rdc(IWR_OFF_STATUS, 32'h0);
      chk(trig_clear, 1'b1);
      apb(1'b1, IWR_OFF_CTRL, 32'h60);
      rdc(IWR_OFF_CTRL, 32'h0);
      rdc(8'h20, 32'h0);
      chk(err, 1'b1);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_start();
      peer_u.set_sda(1'b0);
      apb(1'b1, IWR_OFF_CTRL, 32'h80);
      wt(6);
      apb(1'b0, IWR_OFF_STATUS, 32'h0);
      chk(rd[IWR_ST_START], 1'b1);
      apb(1'b1, IWR_OFF_CTRL, 32'hc0);
      rdc(IWR_OFF_CTRL, 32'h80);
      apb(1'b1, IWR_OFF_IRQ_MASK, 32'h1);
      peer_u.set_sda(1'b1);
      wt(6);
      rdc(IWR_OFF_IRQ_STAT, 32'h0);
      $display("t_start done");
   endtask : t_start
   task automatic t_addr();
      master_i <= 1'b1;
      peer_u.start();
      peer_u.pulse(8);
      wt(6);
      chk(scl_oe_n, 1'b1);
      peer_u.pulse(1);
      wt(6);
      chk(scl_oe_n, 1'b0);
      chk(transfer_irq, 1'b1);
      wt(60);
      chk(scl_oe_n, 1'b0);
      apb(1'b1, IWR_OFF_CTRL, 32'ha0);
      rdc(IWR_OFF_CTRL, 32'h80);
      chk(scl_oe_n, 1'b1);
      apb(1'b1, IWR_OFF_IRQ_STAT, 32'h1);
      chk(transfer_irq, 1'b0);
      $display("t_addr done");
   endtask : t_addr
   task automatic t_data();
      peer_u.pulse(8);
      wt(6);
      chk(scl_oe_n, 1'b0);
      apb(1'b1, IWR_OFF_CTRL, 32'ha0);
      peer_u.pulse(1);
      apb(1'b1, IWR_OFF_CTRL, 32'h88);
      peer_u.pulse(8);
      wt(6);
      chk(scl_oe_n, 1'b1);
      peer_u.pulse(1);
      wt(6);
      chk(scl_oe_n, 1'b0);
      $display("t_data done");
   endtask : t_data
   task automatic t_exit();
      apb(1'b1, IWR_OFF_CTRL, 32'hd8);
      chk(scl_oe_n, 1'b1);
      rdc(IWR_OFF_CTRL, 32'h98);
      apb(1'b0, IWR_OFF_STATUS, 32'h0);
      chk(rd[IWR_ST_WAIT], 1'b0);
      peer_u.pulse(9);
      wt(6);
      chk(scl_oe_n, 1'b1);
      peer_u.stop();
      wt(6);
      rdc(IWR_OFF_IRQ_STAT, 32'h3);
      apb(1'b1, IWR_OFF_IRQ_MASK, 32'h2);
      chk(transfer_irq, 1'b1);
      apb(1'b1, IWR_OFF_IRQ_STAT, 32'h3);
      chk(transfer_irq, 1'b0);
      $display("t_exit done");
   endtask : t_exit
   task automatic t_ext_off();
      master_i <= 1'b0;
      ext_code_i <= 1'b1;
      peer_u.start();
      peer_u.pulse(8);
      wt(6);
      chk(scl_oe_n, 1'b0);
      start_fail_i <= 1'b1;
      wt(1);
      start_fail_i <= 1'b0;
      apb(1'b0, IWR_OFF_FLAG, 32'h0);
      chk(rd[IWR_FL_SFAIL], 1'b1);
      apb(1'b1, IWR_OFF_CTRL, 32'h0);
      wt(2);
      chk(scl_oe_n, 1'b1);
      rdc(IWR_OFF_STATUS, 32'h0);
      rdc(IWR_OFF_FLAG, 32'h0);
      $display("t_ext_off done");
   endtask : t_ext_off
   task automatic t_slave();
      ext_code_i <= 1'b0;
      apb(1'b1, IWR_OFF_CTRL, 32'h80);
      peer_u.stop();
      apb(1'b1, IWR_OFF_CTRL, 32'hc0);
      peer_u.start();
      peer_u.pulse(8);
      wt(6);
      chk(scl_oe_n, 1'b1);
      addr_match_i <= 1'b1;
      dir_i <= 1'b1;
      ack_seen_i <= 1'b1;
      wt(6);
      peer_u.pulse(1);
      wt(6);
      chk(scl_oe_n, 1'b0);
      apb(1'b0, IWR_OFF_STATUS, 32'h0);
      chk({rd[IWR_ST_MATCH], rd[IWR_ST_DIR], rd[IWR_ST_ACK],
         rd[IWR_ST_WAIT]}, 4'hf);
      sda_low_i <= 1'b1;
      wt(4);
      chk({sda_oe_n, scl_o, sda_o}, 3'b000);
      sda_low_i <= 1'b0;
      apb(1'b1, IWR_OFF_CTRL, 32'ha0);
      master_scl_low_i <= 1'b1;
      wt(4);
      chk(scl_oe_n, 1'b0);
      master_scl_low_i <= 1'b0;
      wt(4);
      chk(scl_oe_n, 1'b1);
      $display("t_slave done");
   endtask : t_slave
   initial begin
      n_fail = 0;
      compares = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {master_i, addr_match_i, ext_code_i, start_fail_i} = '0;
      {master_scl_low_i, sda_low_i, dir_i, ack_seen_i} = '0;
      wt(8);
      presetn <= 1'b1;
      wt(2);
      t_reset();
      t_start();
      t_addr();
      t_data();
      t_exit();
      t_ext_off();
      t_slave();
      conclude();
   end
   // watchdog for a hung handshake or wait
   initial begin
      repeat (30000) @(posedge pclk);
      n_fail++;
      conclude();
   end
endmodule : tb
